// >>> tb/plhd_chk_assertions.sv
// bus and holdover output checks on the top ports
// assumes binding into plhd_top, one clock domain
`default_nettype none
module plhd_chk (
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic [7:0] I_ARADDR,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic [1:0] O_RRESP,
	input wire logic [31:0] O_RDATA,
	input wire logic O_REF_CP_TRISTATE,
	input wire logic O_TUNING_DAC_DRIVE,
	input wire logic [9:0] O_TUNING_DAC_CODE
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_NRST);
	// ====================
	// sequences
	sequence s_wr_take;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
	endsequence
	sequence s_in_hold;
		O_TUNING_DAC_DRIVE [*3];
	endsequence
	// ====================
	// properties
	property p_wr_answer;
		s_wr_take |-> ##[1:2] O_BVALID;
	endproperty
	property p_b_stands;
		O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
	endproperty
	property p_rd_answer;
		I_ARVALID && O_ARREADY |=> O_RVALID;
	endproperty
	property p_r_stands;
		O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
	endproperty
	property p_rd_cause;
		$rose(O_RVALID) |-> $past(I_ARVALID);
	endproperty
	property p_unmapped;
		I_ARVALID && O_ARREADY && I_ARADDR > 8'h18 |=> O_RRESP == 2'h2;
	endproperty
	property p_cp_tri;
		O_REF_CP_TRISTATE == O_TUNING_DAC_DRIVE;
	endproperty
	property p_hold_code;
		s_in_hold |-> $stable(O_TUNING_DAC_CODE);
	endproperty
	a_wr_answer: assert property (p_wr_answer)
		else $error("write not answered");
	a_b_stands: assert property (p_b_stands)
		else $error("write response dropped");
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
	a_r_stands: assert property (p_r_stands)
		else $error("read data dropped");
	a_rd_cause: assert property (p_rd_cause)
		else $error("read data without request");
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not refused");
	a_cp_tri: assert property (p_cp_tri)
		else $error("charge pump and dac drive disagree");
	a_hold_code: assert property (p_hold_code)
		else $error("dac code moved in holdover");
endmodule
`default_nettype wire

// >>> tb/plhd_cmp_model.sv
// phase comparator front end model: one comparison every 8 clocks
// assumes the bench holds i_bad steady over whole comparisons
`default_nettype none
module plhd_cmp_model (
	input wire logic i_clk,
	input wire logic i_bad,
	output logic o_stb = 1'b0,
	output logic o_err = 1'b0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] ph = 3'h0;
	// error level is only valid near the strobe; it toggles elsewhere
	always @(posedge i_clk) begin
		ph <= ph + 3'h1;
		o_stb <= (ph == 3'h2) || (ph == 3'h3);
		o_err <= (ph < 3'h6) ? i_bad : ~o_err;
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// bench for lock detection and holdover, registers over the bus
// assumes the comparator model and checker are compiled first
`default_nettype none
bind plhd_top plhd_chk plhd_chk_inst (.*);
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic I_SYS_CLK = 0, I_NRST = 0, I_REF_LOS = 0, I_AWVALID = 0;
	logic I_WVALID = 0, I_BREADY = 0, I_ARVALID = 0, I_RREADY = 0;
	logic I_REF_CMP_STB, I_REF_CMP_ERR, I_SYN_CMP_STB, I_SYN_CMP_ERR;
	logic [9:0] I_TUNE_SAMPLE = 10'h0AB, O_TUNING_DAC_CODE;
	logic [7:0] I_AWADDR = 8'h00, I_ARADDR = 8'h00;
	logic [31:0] I_WDATA = 32'h0, O_RDATA, rd;
	logic [3:0] I_WSTRB = 4'hF;
	logic [1:0] O_BRESP, O_RRESP, rr;
	logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
	logic O_STATUS_PIN_A, O_STATUS_PIN_B, O_REF_CP_TRISTATE;
	logic O_TUNING_DAC_DRIVE, ref_bad = 0;
	int failures = 0, checks_done = 0;
	plhd_top plhd_top_inst (.*);
	plhd_cmp_model plhd_cmp_model_inst (.i_clk(I_SYS_CLK), .i_bad(ref_bad),
		.o_stb(I_REF_CMP_STB), .o_err(I_REF_CMP_ERR));
	plhd_cmp_model syn_model_inst (.i_clk(I_SYS_CLK), .i_bad(1'b0),
		.o_stb(I_SYN_CMP_STB), .o_err(I_SYN_CMP_ERR));
	always #12.5 I_SYS_CLK = ~I_SYS_CLK;
	// ====================
	// helpers
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge I_SYS_CLK);
	endtask
	task drv(input logic bad, input logic los);
		@(posedge I_SYS_CLK);
		ref_bad <= bad;
		I_REF_LOS <= los;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, b;
		@(posedge I_SYS_CLK);
		I_AWADDR <= a;
		I_WDATA <= d;
		I_AWVALID <= 1'b1;
		I_WVALID <= 1'b1;
		I_BREADY <= 1'b1;
		do begin
			@(negedge I_SYS_CLK);
			ta = I_AWVALID && O_AWREADY;
			tw = I_WVALID && O_WREADY;
			b = O_BVALID;
			@(posedge I_SYS_CLK);
			if (ta) I_AWVALID <= 1'b0;
			if (tw) I_WVALID <= 1'b0;
		end while (!b);
		I_BREADY <= 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		logic ta, v;
		@(posedge I_SYS_CLK);
		I_ARADDR <= a;
		I_ARVALID <= 1'b1;
		I_RREADY <= 1'b1;
		do begin
			@(negedge I_SYS_CLK);
			ta = I_ARVALID && O_ARREADY;
			v = O_RVALID;
			rd = O_RDATA;
			rr = O_RRESP;
			@(posedge I_SYS_CLK);
			if (ta) I_ARVALID <= 1'b0;
		end while (!v);
		I_RREADY <= 1'b0;
	endtask
	// ====================
	// scenarios
	task t_reset;
		rdr(plhd_pkg::REG_LOCK_CFG);
		chk("lock_cfg", 32'h04000400, rd);
		rdr(plhd_pkg::REG_HOLD_CFG);
		chk("hold_cfg", 32'h04002000, rd);
		rdr(8'h40);
		chk("unmapped", 32'(plhd_pkg::RESP_SLVERR), 32'(rr));
	endtask
	task t_lock;
		wr(plhd_pkg::REG_LOCK_CFG, 32'h00040004);
		cyc(120);
		chk("pin_a", 32'h1, 32'(O_STATUS_PIN_A));
		chk("pin_b", 32'h1, 32'(O_STATUS_PIN_B));
	endtask
	task t_drop;
		drv(1'b1, 1'b0);
		cyc(20);
		chk("pin_a", 32'h0, 32'(O_STATUS_PIN_A));
		for (int i = 0; i < 3; i++) begin
			wr(plhd_pkg::REG_STATUS_SEL, 32'h10 | 32'(i));
			cyc(3);
			chk("pin_a_sel", 32'(i == 1), 32'(O_STATUS_PIN_A));
		end
		drv(1'b0, 1'b0);
		cyc(10);
		chk("pin_a", 32'h0, 32'(O_STATUS_PIN_A));
		cyc(60);
		chk("pin_a", 32'h1, 32'(O_STATUS_PIN_A));
	endtask
	task t_hold;
		wr(plhd_pkg::REG_STATUS_SEL, 32'h13);
		drv(1'b1, 1'b1);
		cyc(8);
		chk("cp_tri", 32'h0, 32'(O_REF_CP_TRISTATE));
		wr(plhd_pkg::REG_HOLD_CFG, 32'h00041557);
		cyc(6);
		chk("cp_tri", 32'h1, 32'(O_REF_CP_TRISTATE));
		chk("code", 32'h155, 32'(O_TUNING_DAC_CODE));
		chk("pin_a", 32'h1, 32'(O_STATUS_PIN_A));
		chk("pin_b", 32'h1, 32'(O_STATUS_PIN_B));
		rdr(plhd_pkg::REG_STATUS);
		chk("status", 32'h6, 32'(rd[3:1]));
		rdr(plhd_pkg::REG_DAC_RB);
		chk("readback", 32'h155, 32'(rd[9:0]));
		drv(1'b0, 1'b0);
		cyc(80);
		chk("cp_tri", 32'h0, 32'(O_REF_CP_TRISTATE));
	endtask
	task t_track;
		wr(plhd_pkg::REG_DAC_CLK, 32'h00000102);
		wr(plhd_pkg::REG_HOLD_CFG, 32'h00040005);
		cyc(120);
		rdr(plhd_pkg::REG_DAC_RB);
		chk("readback", 32'h0AB, 32'(rd[9:0]));
		rdr(plhd_pkg::REG_STATUS);
		chk("acquired", 32'h1, 32'(rd[4]));
		drv(1'b1, 1'b1);
		cyc(6);
		chk("drive", 32'h1, 32'(O_TUNING_DAC_DRIVE));
		@(posedge I_SYS_CLK);
		I_TUNE_SAMPLE <= 10'h300;
		cyc(40);
		chk("code", 32'h0AB, 32'(O_TUNING_DAC_CODE));
		drv(1'b1, 1'b0);
		I_TUNE_SAMPLE <= 10'h0AB;
		wr(plhd_pkg::REG_STATUS_SEL, 32'h14);
		cyc(4);
		chk("cp_tri", 32'h0, 32'(O_REF_CP_TRISTATE));
		chk("pin_a", 32'h1, 32'(O_STATUS_PIN_A));
	endtask
	task give_verdict;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge I_SYS_CLK);
		I_NRST <= 1'b1;
		t_reset;
		t_lock;
		t_drop;
		t_hold;
		t_track;
		give_verdict;
	end
	// the whole run is well under a thousand cycles
	initial begin
		#100us;
		failures++;
		give_verdict;
	end
endmodule
`default_nettype wire

// >>> verilog/plhd_axil.sv
// AXI4-Lite slave front end: single outstanding write and read
// assumes same clock as the register file; registers live in the top
`default_nettype none
module plhd_axil #(
	parameter int ADDR_W = plhd_pkg::ADDR_W
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_wr,
	output logic [ADDR_W-1:0] o_wr_addr,
	output logic [31:0] o_wr_data,
	output logic [3:0] o_wr_strb,
	input wire logic i_wr_ok,
	output logic o_rd,
	output logic [ADDR_W-1:0] o_rd_addr,
	input wire logic [31:0] i_rd_data,
	input wire logic i_rd_ok
);
	logic aw_full, w_full, bvalid, rvalid;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data, rdata;
	logic [3:0] w_strb;
	logic [1:0] bresp, rresp;
	logic next_aw_full, next_w_full, next_bvalid, next_rvalid;
	logic [ADDR_W-1:0] next_aw_addr;
	logic [31:0] next_w_data, next_rdata;
	logic [3:0] next_w_strb;
	logic [1:0] next_bresp, next_rresp;

	assign o_awready = !aw_full && !bvalid;
	assign o_wready = !w_full && !bvalid;
	assign o_arready = !rvalid;
	assign o_wr = aw_full && w_full && !bvalid;
	assign o_wr_addr = aw_addr;
	assign o_wr_data = w_data;
	assign o_wr_strb = w_strb;
	assign o_rd = i_arvalid && !rvalid;
	assign o_rd_addr = i_araddr;

	always_comb begin
		next_aw_full = aw_full;
		next_w_full = w_full;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (i_awvalid && o_awready) begin
			next_aw_full = 1'b1;
			next_aw_addr = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			next_w_full = 1'b1;
			next_w_data = i_wdata;
			next_w_strb = i_wstrb;
		end
		if (o_wr) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = i_wr_ok ? plhd_pkg::RESP_OKAY : plhd_pkg::RESP_SLVERR;
		end else if (bvalid && i_bready) begin
			next_bvalid = 1'b0;
		end
		if (o_rd) begin
			next_rvalid = 1'b1;
			next_rdata = i_rd_data;
			next_rresp = i_rd_ok ? plhd_pkg::RESP_OKAY : plhd_pkg::RESP_SLVERR;
		end else if (rvalid && i_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			bvalid <= 1'b0;
			bresp <= '0;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= '0;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
		end
	end

	assign o_bvalid = bvalid;
	assign o_bresp = bresp;
	assign o_rvalid = rvalid;
	assign o_rdata = rdata;
	assign o_rresp = rresp;
endmodule
`default_nettype wire

// >>> verilog/plhd_lock_count.sv
// one loop's digital lock counter
// assumes comparison results are one-cycle strobes in the system domain
`default_nettype none
module plhd_lock_count #(
	parameter int CNT_W = plhd_pkg::CNT_W
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire plhd_pkg::plhd_cmp_s i_cmp,
	input wire logic [CNT_W-1:0] i_target,
	output logic o_lock,
	output logic [CNT_W-1:0] o_count
);
	initial begin
		if (CNT_W < 2) $error("CNT_W too small");
	end

	logic [CNT_W-1:0] count;
	logic lock;
	logic [CNT_W-1:0] next_count;
	logic next_lock;

	always_comb begin
		next_count = count;
		next_lock = lock;
		if (i_cmp.valid) begin
			if (i_cmp.in_window) begin
				if (count != i_target)
					next_count = count + 1'b1;
				if (count + 1'b1 >= i_target)
					next_lock = 1'b1;
			end else begin
				next_count = '0;
				next_lock = 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			count <= '0;
			lock <= 1'b0;
		end else begin
			count <= next_count;
			lock <= next_lock;
		end
	end

	assign o_lock = lock;
	assign o_count = count;
endmodule
`default_nettype wire

// >>> verilog/plhd_pkg.sv
// package for the loop lock detect and holdover block
// assumes a single 40 MHz system clock and an AXI4-Lite register port
`default_nettype none
package plhd_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int DAC_W = 10;
	localparam int CNT_W = 14;
	localparam int WND_W = 8;
	localparam int MULT_W = 16;
	localparam int CNTR_W = 8;
	localparam int SEL_W = 3;
	localparam int TRACK_TOL = 2;
	localparam int UPDATE_LIMIT_KHZ = 100;

	// register byte addresses
	localparam logic [ADDR_W-1:0] REG_LOCK_CFG = 8'h00;
	localparam logic [ADDR_W-1:0] REG_STATUS_SEL = 8'h04;
	localparam logic [ADDR_W-1:0] REG_HOLD_CFG = 8'h08;
	localparam logic [ADDR_W-1:0] REG_DAC_CLK = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] REG_DAC_RB = 8'h14;
	localparam logic [ADDR_W-1:0] REG_WINDOW = 8'h18;

	// field positions
	localparam int F_REF_CNT = 0;
	localparam int F_SYN_CNT = 16;
	localparam int F_SEL_A = 0;
	localparam int F_SEL_B = 4;
	localparam int F_HOLD_EN = 0;
	localparam int F_MAN_EN = 1;
	localparam int F_TRACK_EN = 2;
	localparam int F_FORCE = 3;
	localparam int F_MANUAL_DAC_CODE = 4;
	localparam int F_EXIT_CNT = 16;
	localparam int F_CNTR = 0;
	localparam int F_MULT = 8;
	localparam int F_REF_WND = 0;
	localparam int F_SYN_WND = 8;

	// reset values
	localparam logic [CNT_W-1:0] RST_LOCK_CNT = 14'h0400;
	localparam logic [CNT_W-1:0] RST_EXIT_CNT = 14'h0400;
	localparam logic [WND_W-1:0] RST_WND = 8'h04;
	localparam logic [MULT_W-1:0] RST_MULT = 16'h0004;
	localparam logic [CNTR_W-1:0] RST_CNTR = 8'h7F;
	localparam logic [DAC_W-1:0] RST_MANUAL_DAC_CODE = 10'h200;
	localparam logic [SEL_W-1:0] RST_SEL_A = 3'h0;
	localparam logic [SEL_W-1:0] RST_SEL_B = 3'h1;

	localparam logic [SEL_W-1:0] SEL_REF = 3'h0;
	localparam logic [SEL_W-1:0] SEL_SYN = 3'h1;
	localparam logic [SEL_W-1:0] SEL_BOTH = 3'h2;
	localparam logic [SEL_W-1:0] SEL_HOLD = 3'h3;
	localparam logic [SEL_W-1:0] SEL_DACLK = 3'h4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic valid;
		logic in_window;
	} plhd_cmp_s;

	typedef struct packed {
		logic hold_en;
		logic man_en;
		logic track_en;
		logic force_hold;
		logic [DAC_W-1:0] man_code;
		logic [CNT_W-1:0] exit_cnt;
	} plhd_hold_cfg_s;

	typedef enum logic [1:0] {
		ST_LOCKED_LOOP,
		ST_HOLDOVER
	} plhd_hold_e;
endpackage
`default_nettype wire

// >>> verilog/plhd_top.sv
// lock detection for both loops and holdover control of the reference loop
// assumes phase comparator results arrive as pin levels (strobe, out-of-window error)
// from the analog front end and are synchronised here; tracked code comes
// from an external tuning-voltage ADC sampled on the same strobe
// Operation
// - each in-window comparison increments that loop's lock counter up to the lock count
// - lock indicated when counter reaches the programmed lock count
// - one out-of-window comparison drops lock indication at once
// - status pins select reference, synthesizer or both loops' lock
// - holdover only allowed with holdover enable set
// - manual enable drives tuning output with manual code in holdover
// - tracking without manual enable drives tracked code in holdover
// - DAC-acquired flag set once tracking settles, routable to status pins
// - tracked code updates every multiplier times counter reference cycles
// - manual enable wins over tracking at holdover entry
// - present DAC code readable by host at any time
// - acquired tracked code stays within two codes of tuning value
// - holdover entry puts reference charge pump in high impedance
// - reference loop lock deasserted during holdover
// - holdover status asserted and routable to either status pin
// - synthesizer lock kept through holdover if locked at entry and not lost since
// - reference loop keeps comparing during holdover
// - holdover exits when in-window comparisons counted in holdover reach the holdover exit count
`default_nettype none
module plhd_top #(
	parameter int DAC_W = plhd_pkg::DAC_W,
	parameter int CNT_W = plhd_pkg::CNT_W
) (
	input wire logic I_SYS_CLK,
	input wire logic I_NRST,
	input wire logic I_REF_CMP_STB,
	input wire logic I_REF_CMP_ERR,
	input wire logic I_SYN_CMP_STB,
	input wire logic I_SYN_CMP_ERR,
	input wire logic I_REF_LOS,
	input wire logic [DAC_W-1:0] I_TUNE_SAMPLE,
	input wire logic [plhd_pkg::ADDR_W-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [plhd_pkg::ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic O_STATUS_PIN_A,
	output logic O_STATUS_PIN_B,
	output logic O_REF_CP_TRISTATE,
	output logic O_TUNING_DAC_DRIVE,
	output logic [DAC_W-1:0] O_TUNING_DAC_CODE
);
	initial begin
		if (DAC_W != plhd_pkg::DAC_W || CNT_W != plhd_pkg::CNT_W)
			$error("widths must match the register layout");
	end

	//==========================================================
	// input synchronisers
	//==========================================================
	logic [4:0] sync1, sync2;
	logic ref_stb_d, syn_stb_d;
	logic [DAC_W-1:0] tune_s1, tune_s2;
	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			sync1 <= '0;
			sync2 <= '0;
			ref_stb_d <= 1'b0;
			syn_stb_d <= 1'b0;
			tune_s1 <= '0;
			tune_s2 <= '0;
		end else begin
			sync1 <= {I_REF_LOS, I_REF_CMP_STB, I_REF_CMP_ERR,
				I_SYN_CMP_STB, I_SYN_CMP_ERR};
			sync2 <= sync1;
			ref_stb_d <= sync2[3];
			syn_stb_d <= sync2[1];
			tune_s1 <= I_TUNE_SAMPLE;
			tune_s2 <= tune_s1;
		end
	end
	// comparison error pin high means outside the window
	plhd_pkg::plhd_cmp_s ref_cmp, syn_cmp;
	assign ref_cmp.valid = sync2[3] && !ref_stb_d;
	assign ref_cmp.in_window = !sync2[2];
	assign syn_cmp.valid = sync2[1] && !syn_stb_d;
	assign syn_cmp.in_window = !sync2[0];

	//==========================================================
	// registers
	//==========================================================
	logic [CNT_W-1:0] ref_lock_count, synth_loop_lock_count;
	logic [plhd_pkg::SEL_W-1:0] status_a_select, status_b_select;
	plhd_pkg::plhd_hold_cfg_s hcfg;
	logic [plhd_pkg::MULT_W-1:0] dac_clock_multiplier;
	logic [plhd_pkg::CNTR_W-1:0] dac_clock_counter;
	logic [plhd_pkg::WND_W-1:0] ref_loop_window_size, syn_window_size;
	logic cfg_wr;

	logic wr, rd;
	logic [plhd_pkg::ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic wr_ok, rd_ok;

	plhd_axil u_axil (
		.i_clk(I_SYS_CLK),
		.i_nrst(I_NRST),
		.i_awaddr(I_AWADDR),
		.i_awvalid(I_AWVALID),
		.o_awready(O_AWREADY),
		.i_wdata(I_WDATA),
		.i_wstrb(I_WSTRB),
		.i_wvalid(I_WVALID),
		.o_wready(O_WREADY),
		.o_bresp(O_BRESP),
		.o_bvalid(O_BVALID),
		.i_bready(I_BREADY),
		.i_araddr(I_ARADDR),
		.i_arvalid(I_ARVALID),
		.o_arready(O_ARREADY),
		.o_rdata(O_RDATA),
		.o_rresp(O_RRESP),
		.o_rvalid(O_RVALID),
		.i_rready(I_RREADY),
		.o_wr(wr),
		.o_wr_addr(wr_addr),
		.o_wr_data(wr_data),
		.o_wr_strb(wr_strb),
		.i_wr_ok(wr_ok),
		.o_rd(rd),
		.o_rd_addr(rd_addr),
		.i_rd_data(rd_data),
		.i_rd_ok(rd_ok)
	);

	// whole-word writes only; strobes other than all-ones are ignored
	logic wr_full;
	assign wr_full = wr && (wr_strb == 4'hF);
	assign wr_ok = (wr_addr == plhd_pkg::REG_LOCK_CFG) ||
		(wr_addr == plhd_pkg::REG_STATUS_SEL) ||
		(wr_addr == plhd_pkg::REG_HOLD_CFG) ||
		(wr_addr == plhd_pkg::REG_DAC_CLK) ||
		(wr_addr == plhd_pkg::REG_WINDOW);

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ref_lock_count <= plhd_pkg::RST_LOCK_CNT;
			synth_loop_lock_count <= plhd_pkg::RST_LOCK_CNT;
			status_a_select <= plhd_pkg::RST_SEL_A;
			status_b_select <= plhd_pkg::RST_SEL_B;
			hcfg <= '{1'b0, 1'b0, 1'b0, 1'b0, plhd_pkg::RST_MANUAL_DAC_CODE,
				plhd_pkg::RST_EXIT_CNT};
			dac_clock_multiplier <= plhd_pkg::RST_MULT;
			dac_clock_counter <= plhd_pkg::RST_CNTR;
			ref_loop_window_size <= plhd_pkg::RST_WND;
			syn_window_size <= plhd_pkg::RST_WND;
			cfg_wr <= 1'b0;
		end else begin
			cfg_wr <= wr_full && wr_ok;
			if (wr_full) begin
				case (wr_addr)
				plhd_pkg::REG_LOCK_CFG: begin
					ref_lock_count <= wr_data[plhd_pkg::F_REF_CNT +: CNT_W];
					synth_loop_lock_count <= wr_data[plhd_pkg::F_SYN_CNT +: CNT_W];
				end
				plhd_pkg::REG_STATUS_SEL: begin
					status_a_select <= wr_data[plhd_pkg::F_SEL_A +: plhd_pkg::SEL_W];
					status_b_select <= wr_data[plhd_pkg::F_SEL_B +: plhd_pkg::SEL_W];
				end
				plhd_pkg::REG_HOLD_CFG: begin
					hcfg.hold_en <= wr_data[plhd_pkg::F_HOLD_EN];
					hcfg.man_en <= wr_data[plhd_pkg::F_MAN_EN];
					hcfg.track_en <= wr_data[plhd_pkg::F_TRACK_EN];
					hcfg.force_hold <= wr_data[plhd_pkg::F_FORCE];
					hcfg.man_code <= wr_data[plhd_pkg::F_MANUAL_DAC_CODE +: DAC_W];
					hcfg.exit_cnt <= wr_data[plhd_pkg::F_EXIT_CNT +: CNT_W];
				end
				plhd_pkg::REG_DAC_CLK: begin
					dac_clock_counter <= wr_data[plhd_pkg::F_CNTR +: plhd_pkg::CNTR_W];
					dac_clock_multiplier <= wr_data[plhd_pkg::F_MULT +: plhd_pkg::MULT_W];
				end
				plhd_pkg::REG_WINDOW: begin
					ref_loop_window_size <= wr_data[plhd_pkg::F_REF_WND +: plhd_pkg::WND_W];
					syn_window_size <= wr_data[plhd_pkg::F_SYN_WND +: plhd_pkg::WND_W];
				end
				default: begin
				end
				endcase
			end
		end
	end

	//==========================================================
	// lock counters
	//==========================================================
	logic ref_lock_raw, syn_lock_raw;
	logic [CNT_W-1:0] ref_cnt_now;
	plhd_lock_count u_ref_lock (
		.i_clk(I_SYS_CLK),
		.i_nrst(I_NRST),
		.i_cmp(ref_cmp),
		.i_target(ref_lock_count),
		.o_lock(ref_lock_raw),
		.o_count(ref_cnt_now)
	);
	plhd_lock_count u_syn_lock (
		.i_clk(I_SYS_CLK),
		.i_nrst(I_NRST),
		.i_cmp(syn_cmp),
		.i_target(synth_loop_lock_count),
		.o_lock(syn_lock_raw),
		.o_count()
	);

	//==========================================================
	// holdover control
	//==========================================================
	plhd_pkg::plhd_hold_e state, next_state;
	logic [DAC_W-1:0] dac_code, next_dac_code;
	logic dac_acq, next_dac_acq;
	logic syn_keep, next_syn_keep;
	logic [plhd_pkg::MULT_W-1:0] mult_cnt, next_mult_cnt;
	logic [plhd_pkg::CNTR_W-1:0] cntr_cnt, next_cntr_cnt;
	logic hold_cnt_run, next_hold_cnt_run;
	logic [CNT_W-1:0] exit_run, next_exit_run;
	logic in_hold;
	logic entry;
	logic upd;

	assign in_hold = (state == plhd_pkg::ST_HOLDOVER);
	assign entry = hcfg.hold_en && (sync2[4] || hcfg.force_hold);
	// update strobe after multiplier * counter reference comparisons
	assign upd = ref_cmp.valid && (mult_cnt + 1'b1 >= dac_clock_multiplier) &&
		(cntr_cnt + 1'b1 >= dac_clock_counter);

	function automatic logic near_code(input logic [9:0] a, input logic [9:0] b);
		logic [9:0] d;
		d = (a > b) ? a - b : b - a;
		return d <= 10'(plhd_pkg::TRACK_TOL);
	endfunction

	always_comb begin
		next_state = state;
		next_dac_code = dac_code;
		next_dac_acq = dac_acq;
		next_syn_keep = syn_keep;
		next_mult_cnt = mult_cnt;
		next_cntr_cnt = cntr_cnt;
		next_exit_run = exit_run;
		next_hold_cnt_run = hold_cnt_run;
		case (state)
		plhd_pkg::ST_LOCKED_LOOP: begin
			if (hcfg.track_en && ref_cmp.valid) begin
				if (upd) begin
					next_mult_cnt = '0;
					next_cntr_cnt = '0;
					next_dac_code = tune_s2;
					next_dac_acq = near_code(tune_s2, dac_code);
				end else if (mult_cnt + 1'b1 >= dac_clock_multiplier) begin
					next_mult_cnt = '0;
					next_cntr_cnt = cntr_cnt + 1'b1;
				end else begin
					next_mult_cnt = mult_cnt + 1'b1;
				end
			end
			if (!hcfg.track_en)
				next_dac_acq = 1'b0;
			if (entry) begin
				next_state = plhd_pkg::ST_HOLDOVER;
				next_syn_keep = syn_lock_raw;
				next_exit_run = '0;
				next_hold_cnt_run = 1'b0;
				if (hcfg.man_en)
					next_dac_code = hcfg.man_code;
			end
		end
		plhd_pkg::ST_HOLDOVER: begin
			if (hcfg.man_en)
				next_dac_code = hcfg.man_code;
			next_hold_cnt_run = 1'b1;
			if (ref_cmp.valid) begin
				if (!ref_cmp.in_window)
					next_exit_run = '0;
				else if (exit_run != hcfg.exit_cnt)
					next_exit_run = exit_run + 1'b1;
			end
			if (!syn_lock_raw)
				next_syn_keep = 1'b0;
			// manual exit on any configuration write, else once exit_run reaches the exit count; neither while forced
			if (cfg_wr && !hcfg.force_hold)
				next_state = plhd_pkg::ST_LOCKED_LOOP;
			else if (hold_cnt_run && !hcfg.force_hold &&
				exit_run >= hcfg.exit_cnt)
				next_state = plhd_pkg::ST_LOCKED_LOOP;
			if (!hcfg.hold_en)
				next_state = plhd_pkg::ST_LOCKED_LOOP;
		end
		default: next_state = plhd_pkg::ST_LOCKED_LOOP;
		endcase
	end

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			state <= plhd_pkg::ST_LOCKED_LOOP;
			dac_code <= '0;
			dac_acq <= 1'b0;
			syn_keep <= 1'b0;
			mult_cnt <= '0;
			cntr_cnt <= '0;
			exit_run <= '0;
			hold_cnt_run <= 1'b0;
		end else begin
			state <= next_state;
			dac_code <= next_dac_code;
			dac_acq <= next_dac_acq;
			syn_keep <= next_syn_keep;
			mult_cnt <= next_mult_cnt;
			cntr_cnt <= next_cntr_cnt;
			exit_run <= next_exit_run;
			hold_cnt_run <= next_hold_cnt_run;
		end
	end

	//==========================================================
	// status routing and outputs
	//==========================================================
	logic ref_lock, syn_lock;
	assign ref_lock = ref_lock_raw && !in_hold;
	assign syn_lock = in_hold ? syn_keep : syn_lock_raw;

	function automatic logic route(input logic [2:0] sel, input logic r,
		input logic s, input logic h, input logic a);
		case (sel)
		plhd_pkg::SEL_REF: route = r;
		plhd_pkg::SEL_SYN: route = s;
		plhd_pkg::SEL_BOTH: route = r && s;
		plhd_pkg::SEL_HOLD: route = h;
		plhd_pkg::SEL_DACLK: route = a;
		default: route = 1'b0;
		endcase
	endfunction

	always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_STATUS_PIN_A <= 1'b0;
			O_STATUS_PIN_B <= 1'b0;
			O_REF_CP_TRISTATE <= 1'b0;
			O_TUNING_DAC_DRIVE <= 1'b0;
			O_TUNING_DAC_CODE <= '0;
		end else begin
			O_STATUS_PIN_A <= route(status_a_select, ref_lock, syn_lock,
				in_hold, dac_acq);
			O_STATUS_PIN_B <= route(status_b_select, ref_lock, syn_lock,
				in_hold, dac_acq);
			O_REF_CP_TRISTATE <= in_hold;
			O_TUNING_DAC_DRIVE <= in_hold;
			O_TUNING_DAC_CODE <= dac_code;
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		rd_data = '0;
		case (rd_addr)
		plhd_pkg::REG_LOCK_CFG: begin
			rd_data[plhd_pkg::F_REF_CNT +: CNT_W] = ref_lock_count;
			rd_data[plhd_pkg::F_SYN_CNT +: CNT_W] = synth_loop_lock_count;
		end
		plhd_pkg::REG_STATUS_SEL: begin
			rd_data[plhd_pkg::F_SEL_A +: plhd_pkg::SEL_W] = status_a_select;
			rd_data[plhd_pkg::F_SEL_B +: plhd_pkg::SEL_W] = status_b_select;
		end
		plhd_pkg::REG_HOLD_CFG: begin
			rd_data[plhd_pkg::F_HOLD_EN] = hcfg.hold_en;
			rd_data[plhd_pkg::F_MAN_EN] = hcfg.man_en;
			rd_data[plhd_pkg::F_TRACK_EN] = hcfg.track_en;
			rd_data[plhd_pkg::F_FORCE] = hcfg.force_hold;
			rd_data[plhd_pkg::F_MANUAL_DAC_CODE +: DAC_W] = hcfg.man_code;
			rd_data[plhd_pkg::F_EXIT_CNT +: CNT_W] = hcfg.exit_cnt;
		end
		plhd_pkg::REG_DAC_CLK: begin
			rd_data[plhd_pkg::F_CNTR +: plhd_pkg::CNTR_W] = dac_clock_counter;
			rd_data[plhd_pkg::F_MULT +: plhd_pkg::MULT_W] = dac_clock_multiplier;
		end
		plhd_pkg::REG_STATUS:
			rd_data[4:0] = {dac_acq, in_hold, syn_lock, ref_lock, ref_lock_raw};
		plhd_pkg::REG_DAC_RB:
			rd_data[DAC_W-1:0] = dac_code;
		plhd_pkg::REG_WINDOW: begin
			rd_data[plhd_pkg::F_REF_WND +: plhd_pkg::WND_W] = ref_loop_window_size;
			rd_data[plhd_pkg::F_SYN_WND +: plhd_pkg::WND_W] = syn_window_size;
		end
		default: rd_ok = 1'b0;
		endcase
	end
	// window sizes are only stored for read-back; ref count is left unused
	logic unused_ok;
	assign unused_ok = ^ref_cnt_now;
endmodule
`default_nettype wire
